// file: hw/tio_top.sv
// timed serialising i/o ports with their six clock blocks
//
// Functional notes
// - each port is wholly input or wholly output, one direction bit.
// - ports of width 1, 4, 8, 16 and 32 pins exist.
// - ports drive high/low or sample, optionally waiting for a pin condition.
// - every port instruction completes and answers in one cycle.
// - per-port open-collector: zero drives low, one releases the pin.
// - data passes through a shift register and a transfer register.
// - 16-bit counter readable anytime; transfers may wait for a set count.
// - each pin/transfer-register move captures the counter as timestamp.
// - enabled link takes its pins; ports release them.
// - narrower enabled port owns shared pins; wider keeps its other pins.
// - ports always transfer their full nominal width.
// - six clock blocks; block 0 is the 100 MHz reference.
// - a clock block may run from a 1-bit port, optionally divided.
// - input strobe gates sampling; output strobe accompanies output data.
// - after reset every port uses clock block 0.
`timescale 1ns/10ps
`default_nettype none
module tio_top
  import tio_pkg::*;
(
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  // port instructions from the cores
  input wire cmd_t I_CMD,
  output resp_t O_RESP,
  // pins
  input wire logic [31:0] I_PIN_IN,
  output logic [31:0] O_PIN_OUT,
  output logic [31:0] O_PIN_OE,
  // strobes, one per port
  input wire logic [NPORT-1:0] I_STROBE_IN,
  output logic [NPORT-1:0] O_STROBE_OUT,
  // link claims its pins
  input wire logic I_LINK_EN
);

  top_st_t s_q, s_d;
  logic [NCB-1:0] cbtick;
  logic [NPORT-1:0] ptick;
  cb_cfg_t [NCB-1:0] cb_eff;

  // block 0 is pinned to the undivided reference clock
  always_comb begin
    cb_eff = s_q.cb;
    cb_eff[0] = CB_RST;
  end

  // six clock blocks, the external source is the 1-bit port pin
  for (genvar g = 0; g < NCB; g++) begin : g_cb
    tio_clkblk u_cb (
      .i_clk(I_CORE_CLK),
      .i_rst(I_RST),
      .i_cfg(cb_eff[g]),
      .i_ext(I_PIN_IN[0]),
      .o_tick(cbtick[g])
    );
  end

  // instruction handling, port timing, serdes and pin ownership
  always_comb begin
    int w;
    int own;
    logic go;
    logic first;
    logic cond_ok;
    logic take;
    logic [31:0] pv;
    logic [31:0] sh;
    logic [31:0] val;
    port_t p;
    port_t n;
    w = 0;
    own = 0;
    go = 1'b0;
    first = 1'b0;
    cond_ok = 1'b0;
    take = 1'b0;
    pv = 32'h0000_0000;
    sh = 32'h0000_0000;
    val = 32'h0000_0000;
    p = PORT_RST;
    n = PORT_RST;
    s_d = s_q;
    ptick = '0;

    // answer on the next edge, whatever the instruction
    s_d.resp.valid = I_CMD.valid && I_CMD.op != OP_NONE;
    s_d.resp.ok = 1'b0;
    s_d.resp.data = 32'h0000_0000;

    // clock block configuration, block 0 cannot be reprogrammed
    if (I_CMD.valid && I_CMD.op == OP_CBCFG && I_CMD.idx != 3'h0
        && 32'(I_CMD.idx) < NCB) begin
      s_d.cb[I_CMD.idx].ext = I_CMD.data[CBC_EXT];
      s_d.cb[I_CMD.idx].div = I_CMD.data[CBC_DIV_LSB +: 8];
      s_d.resp.ok = 1'b1;
    end

    for (int i = 0; i < NPORT; i++) begin
      p = s_q.port[i];
      n = p;
      w = PORT_W[i];
      if (32'(p.cb_sel) < NCB) begin
        ptick[i] = cbtick[p.cb_sel];
      end

      // instructions first, so hardware events below win over clears
      if (I_CMD.valid && 32'(I_CMD.idx) == i) begin
        unique case (I_CMD.op)
          OP_NONE, OP_CBCFG: begin
          end
          OP_CFG: begin
            n.en = I_CMD.data[CFG_EN];
            n.dir_out = I_CMD.data[CFG_OUT];
            n.oc = I_CMD.data[CFG_OC];
            n.strb_en = I_CMD.data[CFG_STRB];
            n.cb_sel = I_CMD.data[CFG_CB_LSB +: 3];
            n.cond = cond_t'(I_CMD.data[CFG_COND_LSB +: 2]);
            n.left = 6'h00;
            n.xfer_full = 1'b0;
            n.timed = 1'b0;
            s_d.resp.ok = 1'b1;
          end
          OP_COND: begin
            n.cond_val = I_CMD.data & PORT_MASK[i];
            s_d.resp.ok = 1'b1;
          end
          OP_OUT: begin
            // refused while the previous word still waits
            if (p.dir_out && !p.xfer_full) begin
              n.xfer = I_CMD.data;
              n.xfer_full = 1'b1;
              s_d.resp.ok = 1'b1;
            end
          end
          OP_IN: begin
            s_d.resp.data = p.xfer;
            s_d.resp.ok = p.xfer_full;
            if (!p.dir_out) begin
              n.xfer_full = 1'b0;
            end
          end
          OP_SETTIME: begin
            n.time_val = I_CMD.data[15:0];
            n.timed = 1'b1;
            s_d.resp.ok = 1'b1;
          end
          OP_GETCNT: begin
            s_d.resp.data = {16'h0000, p.cnt};
            s_d.resp.ok = 1'b1;
          end
          OP_GETTS: begin
            s_d.resp.data = {16'h0000, p.ts};
            s_d.resp.ok = 1'b1;
          end
          default: begin
            s_d.resp.ok = 1'b0;
          end
        endcase
      end

      // one port clock edge: count, then move data
      if (p.en && ptick[i]) begin
        n.cnt = p.cnt + 16'h0001;
        go = !p.timed || p.cnt == p.time_val;
        if (p.dir_out) begin
          if (p.left > 6'h01) begin
            n.shift = p.shift >> w;
            n.left = p.left - 6'h01;
          end else if (n.xfer_full && go) begin
            n.shift = n.xfer;
            n.left = PORT_SLICES[i];
            n.xfer_full = 1'b0;
            n.ts = p.cnt;
            n.timed = 1'b0;
          end else begin
            n.left = 6'h00;
          end
        end else begin
          // every bit is sampled even where a narrower port owns the pin
          pv = I_PIN_IN & PORT_MASK[i];
          first = p.left == 6'h00;
          unique case (p.cond)
            COND_NONE: cond_ok = 1'b1;
            COND_EQ: cond_ok = pv == p.cond_val;
            COND_NE: cond_ok = pv != p.cond_val;
            default: cond_ok = 1'b0;
          endcase
          take = (!p.strb_en || I_STROBE_IN[i])
            && (!first || (go && cond_ok));
          if (take) begin
            sh = (p.shift >> w) | (pv << (32 - w));
            n.shift = sh;
            if (first) begin
              n.timed = 1'b0;
            end
            if (p.left == PORT_SLICES[i] - 6'h01) begin
              // a full word overwrites one never collected
              n.xfer = sh;
              n.xfer_full = 1'b1;
              n.ts = p.cnt;
              n.left = 6'h00;
            end else begin
              n.left = p.left + 6'h01;
            end
          end
        end
      end
      s_d.strb_out[i] = n.en && n.dir_out && n.left != 6'h00;
      s_d.port[i] = n;
    end

    // pin ownership: the narrowest enabled port covering a pin wins
    for (int b = 0; b < 32; b++) begin
      own = NPORT;
      for (int i = NPORT - 1; i >= 0; i--) begin
        if (s_d.port[i].en && b < PORT_W[i]) begin
          own = i;
        end
      end
      s_d.pin_out[b] = 1'b0;
      s_d.pin_oe[b] = 1'b0;
      if (I_LINK_EN && LINK_MASK[b]) begin
        s_d.pin_oe[b] = 1'b0;
      end else if (own < NPORT) begin
        if (s_d.port[own].dir_out) begin
          val = s_d.port[own].shift;
          s_d.pin_out[b] = val[b];
          s_d.pin_oe[b] = !(s_d.port[own].oc && val[b]);
        end
      end
    end
  end

  // all state in one register
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      s_q.port <= {NPORT{PORT_RST}};
      s_q.cb <= {NCB{CB_RST}};
      s_q.pin_out <= 32'h0000_0000;
      s_q.pin_oe <= 32'h0000_0000;
      s_q.strb_out <= '0;
      s_q.resp <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign O_RESP = s_q.resp;
  assign O_PIN_OUT = s_q.pin_out;
  assign O_PIN_OE = s_q.pin_oe;
  assign O_STROBE_OUT = s_q.strb_out;

  default clocking cb_core @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  sequence s_word_loaded;
    $rose(s_q.port[4].left != 6'h00) && s_q.port[4].dir_out;
  endsequence

  a_resp_one_cycle: assert property (
    I_CMD.valid && I_CMD.op != OP_NONE |=> O_RESP.valid)
    else $error("port instruction not answered in one cycle");

  a_oc_no_high: assert property (
    s_d.port[1].en && s_d.port[1].dir_out && s_d.port[1].oc
      && !s_d.port[0].en && s_d.port[1].shift[1]
      |=> !O_PIN_OE[1])
    else $error("open-collector port drove a one");

  a_link_release: assert property (
    I_LINK_EN |=> (O_PIN_OE & LINK_MASK) == 32'h0000_0000)
    else $error("port drove a pin owned by the link");

  a_narrow_wins: assert property (
    s_d.port[1].en && s_d.port[1].dir_out && !s_d.port[0].en
      |=> O_PIN_OUT[3:0] == s_q.port[1].shift[3:0])
    else $error("low pins not driven by the 4-bit port");

  a_reset_cb_zero: assert property (
    $past(I_RST) |-> s_q.port[0].cb_sel == 3'h0
      && s_q.port[4].cb_sel == 3'h0)
    else $error("port not on clock block 0 after reset");

  a_cnt_step: assert property (
    s_q.port[1].en && ptick[1] && !(I_CMD.valid && I_CMD.idx == 3'h1)
      |=> s_q.port[1].cnt == $past(s_q.port[1].cnt) + 16'h0001)
    else $error("port counter did not step on its clock");

  a_timed_match: assert property (
    $fell(s_q.port[3].timed) && $past(s_q.port[3].en)
      && !$past(I_CMD.valid)
      |-> $past(s_q.port[3].cnt) == $past(s_q.port[3].time_val))
    else $error("timed transfer off its programmed count");

  a_in_timestamp: assert property (
    $rose(s_q.port[2].xfer_full) && !s_q.port[2].dir_out
      |-> s_q.port[2].ts == $past(s_q.port[2].cnt))
    else $error("input word without matching timestamp");

  a_word_through: assert property (
    s_word_loaded
      |-> s_q.port[4].shift == s_q.port[4].xfer
        && O_STROBE_OUT[4])
    else $error("output word not moved from transfer register");

endmodule
`default_nettype wire

// file: hw/tio_pkg.sv
// shared types and constants for the timed i/o ports and clock blocks
package tio_pkg;

  // port set: widths 1, 4, 8, 16 and 32 pins, narrowest first
  localparam int NPORT = 5;
  localparam int NCB = 6;
  localparam int PORT_W [NPORT] = '{1, 4, 8, 16, 32};
  localparam logic [31:0] PORT_MASK [NPORT] = '{
    32'h0000_0001, 32'h0000_000F, 32'h0000_00FF,
    32'h0000_FFFF, 32'hFFFF_FFFF};
  localparam logic [5:0] PORT_SLICES [NPORT] = '{
    6'h20, 6'h08, 6'h04, 6'h02, 6'h01};

  // pins handed to the inter-device link when it is enabled
  localparam logic [31:0] LINK_MASK = 32'hFF00_0000;

  // reference clock rate of clock block 0
  localparam int REF_CLK_MHZ = 100;

  // port configuration word layout
  localparam int CFG_EN = 0;
  localparam int CFG_OUT = 1;
  localparam int CFG_OC = 2;
  localparam int CFG_STRB = 3;
  localparam int CFG_CB_LSB = 4;
  localparam int CFG_COND_LSB = 7;
  // clock block configuration word layout
  localparam int CBC_EXT = 0;
  localparam int CBC_DIV_LSB = 8;

  typedef enum logic [3:0] {
    OP_NONE, OP_CFG, OP_COND, OP_OUT, OP_IN,
    OP_SETTIME, OP_GETCNT, OP_GETTS, OP_CBCFG
  } op_t;

  typedef enum logic [1:0] {COND_NONE, COND_EQ, COND_NE} cond_t;

  typedef struct packed {
    logic valid;
    op_t op;
    logic [2:0] idx;
    logic [31:0] data;
  } cmd_t;

  typedef struct packed {
    logic valid;
    logic ok;
    logic [31:0] data;
  } resp_t;

  typedef struct packed {
    logic ext;
    logic [7:0] div;
  } cb_cfg_t;

  typedef struct packed {
    logic ext_q;
    logic [7:0] cnt;
    logic tick;
  } cb_st_t;

  typedef struct packed {
    logic en;
    logic dir_out;
    logic oc;
    logic strb_en;
    logic [2:0] cb_sel;
    cond_t cond;
    logic [31:0] cond_val;
    logic [31:0] xfer;
    logic [31:0] shift;
    logic xfer_full;
    logic timed;
    logic [5:0] left;
    logic [15:0] cnt;
    logic [15:0] time_val;
    logic [15:0] ts;
  } port_t;

  typedef struct packed {
    port_t [NPORT-1:0] port;
    cb_cfg_t [NCB-1:0] cb;
    logic [31:0] pin_out;
    logic [31:0] pin_oe;
    logic [NPORT-1:0] strb_out;
    resp_t resp;
  } top_st_t;

  // values after reset
  localparam port_t PORT_RST = '0;
  localparam cb_cfg_t CB_RST = '0;
  localparam cb_st_t CBST_RST = '0;

endpackage

// file: hw/tio_clkblk.sv
// one clock block: divided reference or divided 1-bit port clock
`timescale 1ns/10ps
`default_nettype none
module tio_clkblk
  import tio_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // configuration and source
  input wire cb_cfg_t i_cfg,
  input wire logic i_ext,
  // one-cycle tick per block clock edge
  output logic o_tick
);

  cb_st_t s_q, s_d;
  logic rise;

  // edge of the port clock, rate divided by div+1
  always_comb begin
    s_d = s_q;
    rise = i_ext & ~s_q.ext_q;
    s_d.ext_q = i_ext;
    s_d.tick = 1'b0;
    if (!i_cfg.ext || rise) begin
      if (s_q.cnt >= i_cfg.div) begin
        s_d.cnt = 8'h00;
        s_d.tick = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_q <= CBST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_tick = s_q.tick;

  default clocking cb_clk @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_ext_tick_edge: assert property (
    o_tick && $past(i_cfg.ext) |-> $past(rise))
    else $error("external clock tick without a source edge");

  a_ref_div_gap: assert property (
    o_tick && !i_cfg.ext && i_cfg.div == 8'h01 && $stable(i_cfg)
      |=> !o_tick)
    else $error("divided reference ticked on consecutive cycles");

endmodule
`default_nettype wire

// file: tb/tio_pin_model.sv
// pin-side partner: pull-downs, strobed input bytes and a pin clock
`timescale 1ns/10ps
`default_nettype none
module tio_pin_model (
  // clock and design pins
  input wire logic clk,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  // what the design samples
  output logic [31:0] pin_in,
  output logic [4:0] strobe_in
);
  logic [31:0] drv = '0;
  logic [31:0] drv_en = '0;

  // every pin has a pull-down, so a released pin reads low
  assign pin_in = (pin_out & pin_oe) | (drv & drv_en & ~pin_oe);

  initial strobe_in = '0;

  // five bytes on pins 7..0, strobe high only beside valid data
  task automatic feed(input logic [39:0] b);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      drv_en <= 32'h0000_00FF;
      drv[7:0] <= b[8*i +: 8];
      strobe_in[2] <= 1'b1;
    end
    @(posedge clk);
    strobe_in[2] <= 1'b0;
    drv_en <= '0;
  endtask

  // n rising edges on pin 0; the clock stands still afterwards
  task automatic pulses(input int n);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge clk);
      drv_en[0] <= 1'b1;
      drv[0] <= ~drv[0];
      @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// file: tb/tio_top_tb_top.sv
// self-checking bench for the timed i/o ports and clock blocks
`timescale 1ns/10ps
`default_nettype none
module tio_top_tb_top;
  import tio_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic link = 1'b0;
  cmd_t cmd = '0;
  resp_t resp;
  resp_t r;
  logic [31:0] pout;
  logic [31:0] poe;
  logic [31:0] pin;
  logic [4:0] sin;
  logic [4:0] sout;
  logic [15:0] c1;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;

  // 100 MHz core clock
  always #5 clk = ~clk;

  tio_top dut (
    .I_CORE_CLK(clk), .I_RST(rst), .I_CMD(cmd), .O_RESP(resp),
    .I_PIN_IN(pin), .O_PIN_OUT(pout), .O_PIN_OE(poe),
    .I_STROBE_IN(sin), .O_STROBE_OUT(sout), .I_LINK_EN(link)
  );

  tio_pin_model pm (
    .clk(clk), .pin_out(pout), .pin_oe(poe), .pin_in(pin),
    .strobe_in(sin)
  );

  // one comparison, counted
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // counts, verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one instruction; the answer is read 1 ns after the take edge
  task automatic issue(input op_t op, input logic [2:0] idx,
                       input logic [31:0] d);
    @(posedge clk);
    cmd <= '{1'b1, op, idx, d};
    @(posedge clk);
    cmd <= '0;
    #1;
    r = resp;
  endtask

  // length of the strobe_output run of port p, now or next, bounded wait;
  // a word taken at once raises the strobe with the instruction's answer
  task automatic run_len(input int p, input int n);
    int k = 0;
    int h = 0;
    while (k < 40) begin
      if (sout[p] === 1'b1) begin
        h++;
      end else if (h > 0) begin
        break;
      end
      @(posedge clk);
      #1;
      k++;
    end
    chk("strobe cycles", 32'(n), 32'(h));
  endtask

  // idle after reset, block 0 counting, a 32-bit word out, link takeover
  task automatic t_out();
    @(posedge clk);
    #1;
    chk("oe idle", 32'h0, poe);
    chk("strobe idle", 32'h0, 32'(sout));
    issue(OP_CFG, 3'd4, 32'h0000_0003);
    issue(OP_GETCNT, 3'd4, '0);
    chk("getcnt answer", 32'h3, 32'({r.valid, r.ok}));
    c1 = r.data[15:0];
    issue(OP_GETCNT, 3'd4, '0);
    chk("count step", 32'(c1 + 16'd2), 32'(r.data[15:0]));
    issue(OP_OUT, 3'd0, 32'h0000_0001);
    chk("out to input", 32'h0, 32'(r.ok));
    issue(OP_OUT, 3'd4, 32'hA5C3_0F96);
    chk("out answer", 32'h3, 32'({r.valid, r.ok}));
    run_len(4, 1);
    chk("pins", 32'hA5C3_0F96, pout);
    chk("oe", 32'hFFFF_FFFF, poe);
    @(posedge clk);
    link <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("link pins", 32'h00FF_FFFF, poe);
    $display("test out done");
  endtask

  // open-collector nibble port over the wide port's low pins
  task automatic t_oc();
    issue(OP_CFG, 3'd1, 32'h0000_0007);
    issue(OP_OUT, 3'd1, 32'hAAAA_AAAA);
    run_len(1, 8);
    chk("oc enables", 32'h00FF_FFF5, poe);
    chk("oc low", 32'h0, pout & poe & 32'h0000_000F);
    $display("test oc done");
  endtask

  // strobed byte input whose first value must equal, then differ from, 5a
  task automatic t_in();
    issue(OP_CFG, 3'd1, 32'h0);
    for (int m = 0; m < 2; m++) begin
      issue(OP_CFG, 3'd2, m == 0 ? 32'h0000_0089 : 32'h0000_0109);
      issue(OP_COND, 3'd2, 32'h0000_005A);
      issue(OP_IN, 3'd2, '0);
      chk("in empty", 32'h0, 32'(r.ok));
      pm.feed(m == 0 ? 40'h33_2211_5AC3 : 40'h44_3322_115A);
      for (int i = 0; i < 4 && r.ok !== 1'b1; i++) begin
        issue(OP_IN, 3'd2, '0);
      end
      chk("in word", m == 0 ? 32'h3322_115A : 32'h4433_2211,
          r.data);
    end
    $display("test in done");
  endtask

  // output held back until the port count reaches the set time
  task automatic t_timed();
    logic [15:0] t;
    issue(OP_CFG, 3'd2, 32'h0);
    issue(OP_CFG, 3'd3, 32'h0000_0003);
    issue(OP_GETCNT, 3'd3, '0);
    t = r.data[15:0] + 16'd30;
    issue(OP_SETTIME, 3'd3, 32'(t));
    issue(OP_OUT, 3'd3, 32'h7E11_BEEF);
    run_len(3, 2);
    chk("timed pins", 32'h0000_7E11, 32'(pout[15:0]));
    issue(OP_GETTS, 3'd3, '0);
    chk("stamp", 32'(t), 32'(r.data[15:0]));
    $display("test timed done");
  endtask

  // block 0 fixed, six blocks only, block 1 paced by pin 0 halved
  task automatic t_cb();
    issue(OP_CBCFG, 3'd0, 32'h0000_0001);
    chk("cb0 fixed", 32'h0, 32'(r.ok));
    issue(OP_CBCFG, 3'd6, 32'h0000_0001);
    chk("cb6 absent", 32'h0, 32'(r.ok));
    issue(OP_CBCFG, 3'd5, 32'h0000_0100);
    chk("cb5 taken", 32'h1, 32'(r.ok));
    issue(OP_CBCFG, 3'd1, 32'h0000_0101);
    issue(OP_CFG, 3'd0, 32'h0000_0001);
    issue(OP_CFG, 3'd3, 32'h0000_0011);
    issue(OP_GETCNT, 3'd3, '0);
    c1 = r.data[15:0];
    pm.pulses(6);
    repeat (4) @(posedge clk);
    issue(OP_GETCNT, 3'd3, '0);
    chk("ext ticks", 32'(c1 + 16'd3), 32'(r.data[15:0]));
    $display("test cb done");
  endtask

  // reset for 8 cycles, then the scenarios in turn
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_out();
    t_oc();
    t_in();
    t_timed();
    t_cb();
    close_out();
  end

  // about 150 cycles are needed; the ceiling leaves wide margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      chk("cycle limit", 32'h0, 32'h1);
      close_out();
    end
  end
endmodule
`default_nettype wire
